//--- hdl/phyrs_hardware_configuration.sv
// Hardware configuration register: MII clock source, management port
// routing, external port enable, strap readback and self-clearing soft reset.
// Assumes a simple synchronous register port and pins sampled on clock.
//
// Summary of operation
// - Clock selector: 00/11 internal, 01 external, 10 off
// - Clock selector touches only receive/transmit clocks
// - Management select 0 internal PHY, 1 external
// - Management select independent of external port enable
// - Unselected management side driven low or released
// - Presence bit returns strap sampled at reset
// - External enable 1 external port, 0 internal PHY
// - External enable leaves management and clock routing
// - Dead PHY clocks abort reset, set timeout flag
// - Soft reset resets registers, clears error flags
// - Writes ignored until first read after reset
`timescale 1ns/1ps
`default_nettype none
module phyrs_hardware_configuration
  import phyrs_pkg::*;
#(
  parameter int TIMEOUT_CYC = SOFTWARE_RESET_REQUEST_TIMEOUT_CYC
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [REG_W-1:0]  reg_wdata,
  output var  logic [REG_W-1:0]  reg_rdata,
  input  wire logic              pm_wake,
  input  wire logic              int_rx_clk,
  input  wire logic              int_tx_clk,
  input  wire logic              ext_rx_clk,
  input  wire logic              ext_tx_clk,
  output var  logic              mac_rx_clk,
  output var  logic              mac_tx_clk,
  input  wire logic              mgmt_mdc,
  input  wire logic              mgmt_mdio_o,
  input  wire logic              mgmt_mdio_oe,
  output var  logic              mgmt_mdio_i,
  input  wire logic              int_mdio_i,
  output var  logic              int_mdc,
  output var  logic              int_mdio_o,
  output var  logic              int_mdio_oe,
  input  wire logic              ext_mdio_i,
  output var  logic              ext_mdc,
  output var  logic              ext_mdio_o,
  output var  logic              ext_mdio_oe,
  output var  logic              external_port_enable,
  output var  logic              int_phy_enable,
  output var  logic              soft_reset,
  output var  logic              error_flag_clear
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset sequencer
  phyrs_software_reset_request_if sif ();

  phyrs_software_reset_request_seq #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_seq (
    .clock      (clock),
    .rst_n      (rst_n),
    .int_rx_clk (int_rx_clk),
    .int_tx_clk (int_tx_clk),
    .sif        (sif.seq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register fields
  logic [1:0] mii_clock_source_select;
  logic       management_port_select;
  logic       external_port_enable_bit;
  logic       external_phy_present;
  logic       strap_taken;
  logic       soft_reset_timeout_flag;
  logic       read_seen;
  logic [1:0] next_clk_sel;
  logic       next_management_port_select;
  logic       next_ext_en;
  logic       next_to_flag;
  logic       next_read_seen;
  logic       next_req;
  logic [REG_W-1:0] next_rdata;
  logic       hit;
  logic       wr_ok;

  function automatic logic [REG_W-1:0] pack_cfg(input logic [1:0] csel, input logic management_serial_port,
                                                input logic det, input logic en,
                                                input logic to, input logic busy);
    logic [REG_W-1:0] v;
    v = '0;
    v[POS_CLK_SEL +: 2] = csel;
    v[BIT_MANAGEMENT_PORT_SELECT]      = management_serial_port;
    v[BIT_EXT_DET]      = det;
    v[BIT_EXT_EN]       = en;
    v[BIT_SOFT_RESET_TIMEOUT_FLAG]      = to;
    v[BIT_SOFTWARE_RESET_REQUEST]         = busy;
    return v;
  endfunction

  assign hit   = (reg_addr == HARDWARE_CONFIGURATION_OFFSET);
  assign wr_ok = reg_wr && hit && read_seen;

  always_comb begin
    next_clk_sel   = mii_clock_source_select;
    next_management_port_select   = management_port_select;
    next_ext_en    = external_port_enable_bit;
    next_to_flag   = soft_reset_timeout_flag;
    next_read_seen = read_seen;
    next_req       = 1'b0;
    next_rdata     = reg_rdata;
    // Each field is written on its own so routings stay separate
    if (wr_ok && !sif.busy) begin
      next_clk_sel = reg_wdata[POS_CLK_SEL +: 2];
      next_management_port_select = reg_wdata[BIT_MANAGEMENT_PORT_SELECT];
      next_ext_en  = reg_wdata[BIT_EXT_EN];
      if (reg_wdata[BIT_SOFTWARE_RESET_REQUEST]) begin
        next_req     = 1'b1;
        next_to_flag = 1'b0;
      end
    end
    // Completed soft reset returns the fields and the read gate to reset state
    if (sif.done_evt) begin
      next_clk_sel   = CLK_SEL_RST;
      next_management_port_select   = MANAGEMENT_PORT_SELECT_RST;
      next_ext_en    = EXT_EN_RST;
      next_read_seen = 1'b0;
    end
    if (pm_wake) begin
      next_read_seen = 1'b0;
    end
    // A read in the same cycle as a wake or reset end still arms writes
    if (reg_rd && hit) begin
      next_read_seen = 1'b1;
    end
    if (reg_rd) begin
      next_rdata = hit ? pack_cfg(mii_clock_source_select, management_port_select,
                                  external_phy_present, external_port_enable_bit,
                                  soft_reset_timeout_flag, sif.busy) : '0;
    end
    if (sif.timeout_evt) begin
      next_to_flag = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mii_clock_source_select  <= CLK_SEL_RST;
      management_port_select   <= MANAGEMENT_PORT_SELECT_RST;
      external_port_enable_bit <= EXT_EN_RST;
      soft_reset_timeout_flag  <= SOFT_RESET_TIMEOUT_FLAG_RST;
      read_seen                <= 1'b0;
      sif.req                  <= 1'b0;
      reg_rdata                <= '0;
    end else begin
      mii_clock_source_select  <= next_clk_sel;
      management_port_select   <= next_management_port_select;
      external_port_enable_bit <= next_ext_en;
      soft_reset_timeout_flag  <= next_to_flag;
      read_seen                <= next_read_seen;
      sif.req                  <= next_req;
      reg_rdata                <= next_rdata;
    end
  end

  // Strap is caught on the first edge after release, while external MDIO
  // is still released; a soft reset does not recapture it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken          <= 1'b0;
      external_phy_present <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken          <= 1'b1;
      external_phy_present <= ext_mdio_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing
  logic next_rx_clk;
  logic next_tx_clk;
  logic next_mgmt_i;
  logic next_int_mdc;
  logic next_int_o;
  logic next_int_oe;
  logic next_ext_mdc;
  logic next_ext_o;
  logic next_ext_oe;

  always_comb begin
    case (mii_clock_source_select)
      CLK_SRC_EXT: begin
        next_rx_clk = ext_rx_clk;
        next_tx_clk = ext_tx_clk;
      end
      CLK_SRC_OFF: begin
        next_rx_clk = 1'b0;
        next_tx_clk = 1'b0;
      end
      default: begin
        next_rx_clk = int_rx_clk;
        next_tx_clk = int_tx_clk;
      end
    endcase
    if (management_port_select) begin
      next_ext_mdc = mgmt_mdc;
      next_ext_o   = mgmt_mdio_o;
      next_ext_oe  = mgmt_mdio_oe;
      next_mgmt_i  = ext_mdio_i;
      next_int_mdc = 1'b0;
      next_int_o   = 1'b0;
      next_int_oe  = 1'b1;
    end else begin
      next_int_mdc = mgmt_mdc;
      next_int_o   = mgmt_mdio_o;
      next_int_oe  = mgmt_mdio_oe;
      next_mgmt_i  = int_mdio_i;
      next_ext_mdc = 1'b0;
      next_ext_o   = 1'b0;
      next_ext_oe  = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mac_rx_clk           <= 1'b0;
      mac_tx_clk           <= 1'b0;
      mgmt_mdio_i          <= 1'b0;
      int_mdc              <= 1'b0;
      int_mdio_o           <= 1'b0;
      int_mdio_oe          <= 1'b0;
      ext_mdc              <= 1'b0;
      ext_mdio_o           <= 1'b0;
      ext_mdio_oe          <= 1'b0;
      external_port_enable <= 1'b0;
      int_phy_enable       <= 1'b0;
      soft_reset           <= 1'b0;
      error_flag_clear     <= 1'b0;
    end else begin
      mac_rx_clk           <= next_rx_clk;
      mac_tx_clk           <= next_tx_clk;
      mgmt_mdio_i          <= next_mgmt_i;
      int_mdc              <= next_int_mdc;
      int_mdio_o           <= next_int_o;
      int_mdio_oe          <= next_int_oe;
      ext_mdc              <= next_ext_mdc;
      ext_mdio_o           <= next_ext_o;
      ext_mdio_oe          <= next_ext_oe;
      external_port_enable <= external_port_enable_bit;
      int_phy_enable       <= !external_port_enable_bit;
      soft_reset           <= sif.active;
      error_flag_clear     <= sif.done_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_clk_ext;
    mii_clock_source_select == CLK_SRC_EXT |=> mac_rx_clk == $past(ext_rx_clk)
                                             && mac_tx_clk == $past(ext_tx_clk);
  endproperty
  a_clk_ext: assert property (p_clk_ext) else $error("external clock not routed");

  property p_clk_off;
    mii_clock_source_select == CLK_SRC_OFF [*2] |-> !mac_rx_clk && !mac_tx_clk;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clocks not disabled");

  property p_smi_int;
    !management_port_select |=> int_mdc == $past(mgmt_mdc) && !ext_mdc && !ext_mdio_oe;
  endproperty
  a_smi_int: assert property (p_smi_int) else $error("internal routing wrong");

  property p_smi_ext;
    management_port_select |=> ext_mdc == $past(mgmt_mdc) && int_mdio_oe && !int_mdio_o
                              && !int_mdc && mgmt_mdio_i == $past(ext_mdio_i);
  endproperty
  a_smi_ext: assert property (p_smi_ext) else $error("external routing wrong");

  property p_strap;
    $rose(strap_taken) |-> external_phy_present == $past(ext_mdio_i) ##1 $stable(external_phy_present);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");

  property p_ext_en;
    wr_ok && !sif.busy && !sif.done_evt |=> ##1 external_port_enable == $past(reg_wdata[BIT_EXT_EN], 2)
                                            && int_phy_enable != external_port_enable;
  endproperty
  a_ext_en: assert property (p_ext_en) else $error("external enable not applied");

  property p_gate;
    reg_wr && hit && !read_seen && !sif.done_evt |=> $stable(mii_clock_source_select)
      && $stable(management_port_select) && $stable(external_port_enable_bit) && !sif.req;
  endproperty
  a_gate: assert property (p_gate) else $error("write acted before read");

  property p_to_flag;
    sif.timeout_evt |=> soft_reset_timeout_flag && !soft_reset;
  endproperty
  a_to_flag: assert property (p_to_flag) else $error("timeout flag not set");

  property p_busy_read;
    reg_rd && hit && sif.busy |=> reg_rdata[BIT_SOFTWARE_RESET_REQUEST];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("reset bit not busy");

  property p_software_reset_request_done;
    sif.done_evt |=> error_flag_clear && mii_clock_source_select == CLK_SEL_RST
                     && read_seen == $past(reg_rd && hit);
  endproperty
  a_software_reset_request_done: assert property (p_software_reset_request_done) else $error("soft reset effects missing");

  c_smi_switch: cover property ($rose(management_port_select));
  c_rd_then_wr: cover property (reg_rd && hit ##1 wr_ok);
  c_clk_ext:    cover property (mii_clock_source_select == CLK_SRC_EXT ##1 $rose(mac_rx_clk));

endmodule
`default_nettype wire

//--- hdl/phyrs_pkg.sv
// Constants for the PHY path select and soft reset register block.
// Assumes a 200 MHz single clock domain and one 32-bit register slot.
package phyrs_pkg;

  // Register slot
  localparam logic [7:0]  HARDWARE_CONFIGURATION_OFFSET      = 8'h74;
  localparam int          REG_W              = 32;

  // Field positions inside hardware_configuration
  localparam int          BIT_SOFTWARE_RESET_REQUEST           = 0;
  localparam int          BIT_SOFT_RESET_TIMEOUT_FLAG        = 1;
  localparam int          BIT_EXT_EN         = 2;
  localparam int          BIT_EXT_DET        = 3;
  localparam int          BIT_MANAGEMENT_PORT_SELECT        = 4;
  localparam int          POS_CLK_SEL        = 5;

  // Reset values
  localparam logic [1:0]  CLK_SEL_RST        = 2'h0;
  localparam logic        MANAGEMENT_PORT_SELECT_RST        = 1'b0;
  localparam logic        EXT_EN_RST         = 1'b0;
  localparam logic        SOFT_RESET_TIMEOUT_FLAG_RST        = 1'b0;

  // Clock source encodings
  localparam logic [1:0]  CLK_SRC_INT0       = 2'h0;
  localparam logic [1:0]  CLK_SRC_EXT        = 2'h1;
  localparam logic [1:0]  CLK_SRC_OFF        = 2'h2;
  localparam logic [1:0]  CLK_SRC_INT1       = 2'h3;

  // Timing
  localparam int          CLK_PERIOD_NS      = 5;
  localparam int          SOFTWARE_RESET_REQUEST_TIMEOUT_NS    = 10000;
  localparam int          SOFTWARE_RESET_REQUEST_TIMEOUT_CYC   = SOFTWARE_RESET_REQUEST_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int          SOFTWARE_RESET_REQUEST_PULSE_NS      = 40;
  localparam int          SOFTWARE_RESET_REQUEST_PULSE_CYC     = (SOFTWARE_RESET_REQUEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SEQ_CNT_W          = 16;

  typedef enum logic [1:0] {PHYRS_IDLE, PHYRS_WAIT, PHYRS_PULSE} phyrs_seq_e;

endpackage

//--- hdl/phyrs_software_reset_request_if.sv
// Handshake between the register bank and the soft reset sequencer.
// Assumes both ends share the one block clock.
`timescale 1ns/1ps
`default_nettype none
interface phyrs_software_reset_request_if;
  logic req;
  logic busy;
  logic active;
  logic timeout_evt;
  logic done_evt;

  modport bank (output req, input busy, input active, input timeout_evt, input done_evt);
  modport seq  (input req, output busy, output active, output timeout_evt, output done_evt);
endinterface
`default_nettype wire

//--- hdl/phyrs_software_reset_request_seq.sv
// Soft reset sequencer: waits for the internal PHY clocks, then pulses reset.
// Assumes internal PHY clocks arrive as levels synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module phyrs_software_reset_request_seq
  import phyrs_pkg::*;
#(
  parameter int TIMEOUT_CYC = SOFTWARE_RESET_REQUEST_TIMEOUT_CYC
) (
  input  wire logic     clock,
  input  wire logic     rst_n,
  input  wire logic     int_rx_clk,
  input  wire logic     int_tx_clk,
  phyrs_software_reset_request_if.seq     sif
);

  phyrs_seq_e              state;
  phyrs_seq_e              next_state;
  logic [SEQ_CNT_W-1:0]    cnt;
  logic [SEQ_CNT_W-1:0]    next_cnt;
  logic                    rx_prev;
  logic                    tx_prev;
  logic                    rx_seen;
  logic                    tx_seen;
  logic                    next_rx_seen;
  logic                    next_tx_seen;
  logic                    next_timeout;
  logic                    next_done;
  logic                    timeout_evt;
  logic                    done_evt;
  logic [SEQ_CNT_W-1:0]    busy_cyc;
  logic [SEQ_CNT_W-1:0]    next_busy_cyc;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_rx_seen = rx_seen | (int_rx_clk != rx_prev);
    next_tx_seen = tx_seen | (int_tx_clk != tx_prev);
    next_timeout = 1'b0;
    next_done    = 1'b0;
    // Busy length is tracked so a stuck wait is caught at any timeout setting up to 65527 cycles
    next_busy_cyc = sif.busy ? busy_cyc + SEQ_CNT_W'(1) : '0;
    case (state)
      PHYRS_IDLE: begin
        next_rx_seen = 1'b0;
        next_tx_seen = 1'b0;
        next_cnt     = '0;
        if (sif.req) begin
          next_state = PHYRS_WAIT;
        end
      end
      PHYRS_WAIT: begin
        // Reset only proceeds once both PHY clocks are seen toggling
        if (next_rx_seen && next_tx_seen) begin
          next_state = PHYRS_PULSE;
          next_cnt   = '0;
        end else if (cnt == SEQ_CNT_W'(TIMEOUT_CYC - 1)) begin
          next_state   = PHYRS_IDLE;
          next_timeout = 1'b1;
        end else begin
          next_cnt = cnt + SEQ_CNT_W'(1);
        end
      end
      PHYRS_PULSE: begin
        if (cnt == SEQ_CNT_W'(SOFTWARE_RESET_REQUEST_PULSE_CYC - 1)) begin
          next_state = PHYRS_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt + SEQ_CNT_W'(1);
        end
      end
      default: begin
        next_state = PHYRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state       <= PHYRS_IDLE;
      cnt         <= '0;
      rx_prev     <= 1'b0;
      tx_prev     <= 1'b0;
      rx_seen     <= 1'b0;
      tx_seen     <= 1'b0;
      timeout_evt <= 1'b0;
      done_evt    <= 1'b0;
      busy_cyc    <= '0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      rx_prev     <= int_rx_clk;
      tx_prev     <= int_tx_clk;
      rx_seen     <= next_rx_seen;
      tx_seen     <= next_tx_seen;
      timeout_evt <= next_timeout;
      done_evt    <= next_done;
      busy_cyc    <= next_busy_cyc;
    end
  end

  assign sif.busy        = (state != PHYRS_IDLE);
  assign sif.active      = (state == PHYRS_PULSE);
  assign sif.timeout_evt = timeout_evt;
  assign sif.done_evt    = done_evt;

  ////////////////////////////////////////////////////////////////////////////
  property p_timeout_cause;
    @(posedge clock) disable iff (!rst_n)
      timeout_evt |-> $past(state) == PHYRS_WAIT && $past(cnt) == SEQ_CNT_W'(TIMEOUT_CYC - 1);
  endproperty
  a_timeout_cause: assert property (p_timeout_cause) else $error("timeout without full wait");

  property p_pulse_len;
    @(posedge clock) disable iff (!rst_n)
      $rose(sif.active) |-> sif.active[*8] ##1 (!sif.active && done_evt);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

  property p_busy_covers;
    @(posedge clock) disable iff (!rst_n)
      sif.req && !sif.busy |=> sif.busy;
  endproperty
  a_busy_covers: assert property (p_busy_covers) else $error("busy not raised");

  property p_busy_end;
    @(posedge clock) disable iff (!rst_n)
      $fell(sif.busy) |-> timeout_evt || done_evt;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy dropped early");

  // Longest legal busy time is the full wait plus the reset pulse
  property p_busy_bound;
    @(posedge clock) disable iff (!rst_n)
      sif.busy |-> busy_cyc < SEQ_CNT_W'(TIMEOUT_CYC + SOFTWARE_RESET_REQUEST_PULSE_CYC);
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("sequencer stuck");

  c_timeout: cover property (@(posedge clock) disable iff (!rst_n) timeout_evt);
  c_done:    cover property (@(posedge clock) disable iff (!rst_n) done_evt);

endmodule
`default_nettype wire

//--- tb/phy_path_select_soft_reset_bench.sv
// Self-checking bench for the hardware configuration register block.
// Assumes the PHY model runs the PHY clocks and answers on the MDIO lines.
`timescale 1ns/1ps
`default_nettype none
module phy_path_select_soft_reset_bench;
  import phyrs_pkg::*;
  localparam int TO_CYC = 20;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, cur, d;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, pm_wake = 1'b0;
  logic        ext_rx_clk = 1'b0, ext_tx_clk = 1'b0;
  logic        mgmt_mdc = 1'b0, mgmt_mdio_o = 1'b0, mgmt_mdio_oe = 1'b0;
  logic        clk_run = 1'b1, talk = 1'b0, pull_up = 1'b1, det = 1'b1;
  logic        int_rx_clk, int_tx_clk, mac_rx_clk, mac_tx_clk, mgmt_mdio_i, int_mdio_i;
  logic        int_mdc, int_mdio_o, int_mdio_oe, ext_mdio_i, ext_mdc, ext_mdio_o, ext_mdio_oe;
  logic        external_port_enable, int_phy_enable, soft_reset, error_flag_clear;
  logic [8:0]  pv;
  int          err_total = 0, check_count = 0, hi, clr;

  always #2.5 clock = ~clock;

  phyrs_hardware_configuration #(.TIMEOUT_CYC(TO_CYC)) phyrs_hardware_configuration_i (
    .clock, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pm_wake,
    .int_rx_clk, .int_tx_clk, .ext_rx_clk, .ext_tx_clk, .mac_rx_clk, .mac_tx_clk,
    .mgmt_mdc, .mgmt_mdio_o, .mgmt_mdio_oe, .mgmt_mdio_i, .int_mdio_i, .int_mdc,
    .int_mdio_o, .int_mdio_oe, .ext_mdio_i, .ext_mdc, .ext_mdio_o, .ext_mdio_oe,
    .external_port_enable, .int_phy_enable, .soft_reset, .error_flag_clear
  );
  phyrs_phy_model phyrs_phy_model_i (
    .clock, .clk_run, .talk, .pull_up, .int_mdio_o, .int_mdio_oe, .ext_mdio_o,
    .ext_mdio_oe, .int_rx_clk, .int_tx_clk, .int_mdio_i, .ext_mdio_i
  );
  // Inputs as the block saw them at the last rising edge
  always @(posedge clock)
    pv <= {int_rx_clk, int_tx_clk, ext_rx_clk, ext_tx_clk, mgmt_mdc, mgmt_mdio_o,
           mgmt_mdio_oe, int_mdio_i, ext_mdio_i};
  // Pulse counts run in the background so no cycle of a reset is missed
  always @(negedge clock) begin
    hi += soft_reset;
    clr += error_flag_clear;
  end
  ////////////////////////////////////////
  function automatic logic exp_clk(input logic [1:0] sel, input logic i, input logic e);
    case (sel)
      CLK_SRC_EXT: return e;
      CLK_SRC_OFF: return 1'b0;
      default:     return i;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask

  // No traffic runs here, so the MAC is always halted when written
  task automatic wr(input logic [31:0] v);
    @(negedge clock);
    reg_addr = HARDWARE_CONFIGURATION_OFFSET;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic chkreg(input string nm, input logic to, input logic busy);
    rd(HARDWARE_CONFIGURATION_OFFSET, d);
    chk(nm, (cur & 32'h00000074) | {28'h0, det, 1'b0, to, busy}, d);
  endtask

  task automatic do_reset(input logic pu);
    @(negedge clock);
    nrst = 1'b0;
    talk = 1'b0;
    pull_up = pu;
    det = pu;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    // Strap must hold well past the internal reset release
    repeat (6) @(negedge clock);
    talk = 1'b1;
    cur = 32'h0;
  endtask

  // Checks every routed pin against the fields held in cur
  task automatic step(input int n);
    logic [1:0] sel;
    logic       management_serial_port, en;
    sel = cur[6:5];
    management_serial_port = cur[4];
    en = cur[2];
    repeat (n) begin
      @(negedge clock);
      chk("mac_rx_clk", exp_clk(sel, pv[8], pv[6]), mac_rx_clk);
      chk("mac_tx_clk", exp_clk(sel, pv[7], pv[5]), mac_tx_clk);
      chk("int_side", management_serial_port ? 3'b010 : {pv[4], pv[2], pv[3]},
          {int_mdc, int_mdio_oe, int_mdio_o});
      chk("ext_side", management_serial_port ? {pv[4], pv[2], pv[3]} : 3'b000,
          {ext_mdc, ext_mdio_oe, ext_mdio_o});
      chk("mgmt_mdio_i", management_serial_port ? pv[0] : pv[1], mgmt_mdio_i);
      chk("port_enable", {en, ~en}, {external_port_enable, int_phy_enable});
      {ext_rx_clk, ext_tx_clk, mgmt_mdc, mgmt_mdio_o, mgmt_mdio_oe} = 5'($urandom);
    end
  endtask

  task automatic software_reset_request(input logic ok);
    int h0;
    int c0;
    h0 = hi;
    c0 = clr;
    wr(cur | 32'h00000001);
    @(negedge clock);
    rd(HARDWARE_CONFIGURATION_OFFSET, d);
    chk("reset_busy", 32'h1, {31'h0, d[0]});
    // Refused while busy, so it must leave no trace
    wr(32'h00000010);
    repeat (TO_CYC + 40) @(negedge clock);
    chk("soft_reset_len", ok ? SOFTWARE_RESET_REQUEST_PULSE_CYC : 0, hi - h0);
    chk("flag_clear", {31'h0, ok}, clr - c0);
    if (ok) begin
      cur = 32'h0;
      wr(32'h00000064);
    end
    chkreg("after_reset", ~ok, 1'b0);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(58));
    do_reset(1'b1);
    wr(32'h00000064);
    chkreg("hardware_configuration_reset", 1'b0, 1'b0);
    rd(8'h70, d);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 12; i++) begin
      d = $urandom & 32'hFFFFFFFE;
      if (i < 4)
        d[6:5] = i[1:0];
      wr(d);
      cur = d & 32'h00000074;
      chkreg("hardware_configuration_rw", 1'b0, 1'b0);
      step(8);
    end
    software_reset_request(1'b1);
    step(4);
    clk_run = 1'b0;
    cur = 32'h00000034;
    wr(cur);
    software_reset_request(1'b0);
    step(4);
    clk_run = 1'b1;
    repeat (4) @(negedge clock);
    software_reset_request(1'b1);
    @(negedge clock);
    pm_wake = 1'b1;
    @(negedge clock);
    pm_wake = 1'b0;
    wr(32'h00000064);
    chkreg("wake_gate", 1'b0, 1'b0);
    do_reset(1'b0);
    chkreg("strap_low", 1'b0, 1'b0);
    wrap_up;
  end

  initial begin
    #200000;
    err_total++;
    wrap_up;
  end
endmodule
`default_nettype wire

//--- tb/phyrs_phy_model.sv
// Behavioural model of the internal PHY and an optional external PHY.
// Assumes the MDIO lines are resolved here from the block's output enables.
`timescale 1ns/1ps
`default_nettype none
module phyrs_phy_model (
  input  wire logic clock,
  input  wire logic clk_run,
  input  wire logic talk,
  input  wire logic pull_up,
  input  wire logic int_mdio_o,
  input  wire logic int_mdio_oe,
  input  wire logic ext_mdio_o,
  input  wire logic ext_mdio_oe,
  output wire logic int_rx_clk,
  output wire logic int_tx_clk,
  output wire logic int_mdio_i,
  output wire logic ext_mdio_i
);
  logic phase = 1'b0;
  logic tick  = 1'b0;
  ////////////////////////////////////////
  // Clocks stand still while the PHY is not operational
  always @(posedge clock) begin
    tick <= ~tick;
    if (clk_run)
      phase <= ~phase;
  end
  assign int_rx_clk = phase;
  assign int_tx_clk = ~phase;
  ////////////////////////////////////////
  // A released line never keeps its last value: the internal one has no
  // pull so the PHY toggles it; the external one rests on its strap pull until talk, then toggles
  assign int_mdio_i = int_mdio_oe ? int_mdio_o : tick;
  assign ext_mdio_i = ext_mdio_oe ? ext_mdio_o : (talk ? ~tick : pull_up);
endmodule
`default_nettype wire
